// ---- src/irq_route_pkg.sv ----
// Package for the interrupt and transfer-request routing block
// Assumes an AHB-Lite bus with 32-bit data and a single slave
package irq_route_pkg;

    // ========================================
    // Register offsets (byte addresses)
    localparam logic [7:0] SELECT_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET   = 8'h08;
    localparam logic [7:0] LEVEL_OFFSET  = 8'h0C;

    // ========================================
    // Select bit positions
    localparam int SEL_ADC1_BIT    = 6;
    localparam int SEL_ADC2_BIT    = 7;
    localparam int SEL_BT0_BIT     = 8;
    localparam int SEL_BT2_BIT     = 9;
    localparam int SEL_BT4_BIT     = 10;
    localparam int SEL_BT6_BIT     = 11;
    localparam int SEL_SER0_RX_BIT = 12;
    localparam int SEL_SER0_TX_BIT = 13;
    localparam int SEL_SER1_RX_BIT = 14;
    localparam int SEL_LOW_BIT     = 6;
    localparam int SEL_HIGH_BIT    = 14;
    localparam int NUM_SOURCES     = 9;

    // ========================================
    // Reset values
    localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    // ========================================
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic [1:0] HRESP_OKAY    = 2'h0;

endpackage

// ---- src/source_sync.sv ----
// Two-stage synchroniser with rising-edge detect for routed sources
// Assumes asynchronous source levels and an active-low async reset
`timescale 1ns/100ps
`default_nettype none
module source_sync #(
    parameter int WIDTH = 9
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] rise_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] prev_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_next;
    logic [WIDTH-1:0] prev_next;

    if (WIDTH < 1)
    begin
        $error("source_sync: WIDTH must be at least 1");
    end

    always_comb
    begin
        meta_next = async_in;
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    assign level_out = sync_reg;
    assign rise_out  = sync_reg & ~prev_reg;

endmodule
`default_nettype wire

// ---- src/irq_dma_request_router.sv ----
// Routes each peripheral interrupt source to the processor or the DMA
// Assumes AHB-Lite single-word transfers, sources from other clock domains
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Bit 14 routes serial 1 receive
// - Bit 13 routes serial 0 transmit
// - Bit 12 routes serial 0 receive
// - Bit 11 routes timer 6 line
// - Bit 10 routes timer 4 line
// - Bit 9 routes timer 2 line
// - Bit 8 routes timer 0 line
// - Bit 7 routes converter 2 scan
// - Bit 6 routes converter 1 scan
module irq_dma_request_router
    import irq_route_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic      [1:0]  hresp,
    input  wire logic        ser1_rx_irq,
    input  wire logic        ser0_tx_irq,
    input  wire logic        ser0_rx_irq,
    input  wire logic        timer6_irq0,
    input  wire logic        timer4_irq0,
    input  wire logic        timer2_irq0,
    input  wire logic        timer0_irq0,
    input  wire logic        adc2_scan_irq,
    input  wire logic        adc1_scan_irq,
    output logic [NUM_SOURCES-1:0] cpu_irq,
    output logic [NUM_SOURCES-1:0] dma_controller_req,
    output logic             router_irq
);
    import irq_route_pkg::*;

    // ========================================
    // Elaboration checks
    if (SEL_HIGH_BIT - SEL_LOW_BIT + 1 != NUM_SOURCES)
    begin
        $error("Select field width differs from the source count");
    end
    if (SEL_LOW_BIT < 0 || SEL_HIGH_BIT > 31)
    begin
        $error("Select field lies outside the data word");
    end
    if (SEL_ADC1_BIT != SEL_LOW_BIT || SEL_SER1_RX_BIT != SEL_HIGH_BIT)
    begin
        $error("Source bits do not span the select field");
    end

    // ========================================
    // Source synchronisers
    logic [NUM_SOURCES-1:0] src_raw;
    logic [NUM_SOURCES-1:0] src_level;
    logic [NUM_SOURCES-1:0] src_rise;

    // Index 0 is select bit 6, index 8 is select bit 14
    assign src_raw = {ser1_rx_irq, ser0_tx_irq, ser0_rx_irq,
                      timer6_irq0, timer4_irq0, timer2_irq0, timer0_irq0,
                      adc2_scan_irq, adc1_scan_irq};

    source_sync #(
        .WIDTH (NUM_SOURCES)
    ) u_sync (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .async_in  (src_raw),
        .level_out (src_level),
        .rise_out  (src_rise)
    );

    // ========================================
    // Bus address phase capture
    logic       wr_pend_reg;
    logic       rd_pend_reg;
    logic [7:0] addr_reg;
    logic       wr_pend_next;
    logic       rd_pend_next;
    logic [7:0] addr_next;
    logic       take;

    assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

    always_comb
    begin
        wr_pend_next = take && hwrite;
        rd_pend_next = take && !hwrite;
        addr_next    = take ? haddr[7:0] : addr_reg;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            addr_reg    <= addr_next;
        end
    end

    // ========================================
    // Registers
    logic [NUM_SOURCES-1:0] select_reg;
    logic [NUM_SOURCES-1:0] mask_reg;
    logic [NUM_SOURCES-1:0] status_reg;
    logic [31:0]            hrdata_reg;
    logic [NUM_SOURCES-1:0] select_next;
    logic [NUM_SOURCES-1:0] mask_next;
    logic [NUM_SOURCES-1:0] status_next;
    logic [31:0]            hrdata_next;
    logic                   status_clear;

    function automatic logic [31:0] place(input logic [NUM_SOURCES-1:0] f);
        place = 32'h0000_0000;
        place[SEL_HIGH_BIT:SEL_LOW_BIT] = f;
    endfunction

    function automatic logic [NUM_SOURCES-1:0] pick(input logic [31:0] w);
        pick = w[SEL_HIGH_BIT:SEL_LOW_BIT];
    endfunction

    // ========================================
    // Routing and mask settings
    always_comb
    begin
        select_next = select_reg;
        mask_next   = mask_reg;
        if (wr_pend_reg)
        begin
            case (addr_reg)
                SELECT_OFFSET: select_next = pick(hwdata);
                MASK_OFFSET:   mask_next   = pick(hwdata);
                default:       ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            select_reg <= SELECT_RESET[SEL_HIGH_BIT:SEL_LOW_BIT];
            mask_reg   <= MASK_RESET[SEL_HIGH_BIT:SEL_LOW_BIT];
        end
        else
        begin
            select_reg <= select_next;
            mask_reg   <= mask_next;
        end
    end

    // ========================================
    // Sticky event status
    assign status_clear = rd_pend_reg && (addr_reg == STATUS_OFFSET);

    always_comb
    begin
        // New events win over a clear in the same cycle
        status_next = status_clear ? '0 : status_reg;
        status_next = status_next | src_rise;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status_reg <= STATUS_RESET[SEL_HIGH_BIT:SEL_LOW_BIT];
        else
            status_reg <= status_next;
    end

    // ========================================
    // Read data, valid in the data phase
    always_comb
    begin
        hrdata_next = 32'h0000_0000;
        if (rd_pend_next)
        begin
            case (haddr[7:0])
                SELECT_OFFSET: hrdata_next = place(select_reg);
                STATUS_OFFSET: hrdata_next = place(status_next);
                MASK_OFFSET:   hrdata_next = place(mask_reg);
                LEVEL_OFFSET:  hrdata_next = place(src_level);
                default:       hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_reg <= 32'h0000_0000;
        else
            hrdata_reg <= hrdata_next;
    end

    // ========================================
    // Routing
    logic [NUM_SOURCES-1:0] cpu_next;
    logic [NUM_SOURCES-1:0] dma_next;
    logic [NUM_SOURCES-1:0] cpu_reg;
    logic [NUM_SOURCES-1:0] dma_reg;
    logic                   irq_next;
    logic                   irq_reg;

    always_comb
    begin
        cpu_next = '0;
        dma_next = '0;
        cpu_next[SEL_SER1_RX_BIT-SEL_LOW_BIT] =
            src_level[SEL_SER1_RX_BIT-SEL_LOW_BIT] & ~select_next[SEL_SER1_RX_BIT-SEL_LOW_BIT];
        cpu_next[SEL_SER0_TX_BIT-SEL_LOW_BIT] =
            src_level[SEL_SER0_TX_BIT-SEL_LOW_BIT] & ~select_next[SEL_SER0_TX_BIT-SEL_LOW_BIT];
        cpu_next[SEL_SER0_RX_BIT-SEL_LOW_BIT] =
            src_level[SEL_SER0_RX_BIT-SEL_LOW_BIT] & ~select_next[SEL_SER0_RX_BIT-SEL_LOW_BIT];
        cpu_next[SEL_BT6_BIT-SEL_LOW_BIT] =
            src_level[SEL_BT6_BIT-SEL_LOW_BIT] & ~select_next[SEL_BT6_BIT-SEL_LOW_BIT];
        cpu_next[SEL_BT4_BIT-SEL_LOW_BIT] =
            src_level[SEL_BT4_BIT-SEL_LOW_BIT] & ~select_next[SEL_BT4_BIT-SEL_LOW_BIT];
        cpu_next[SEL_BT2_BIT-SEL_LOW_BIT] =
            src_level[SEL_BT2_BIT-SEL_LOW_BIT] & ~select_next[SEL_BT2_BIT-SEL_LOW_BIT];
        cpu_next[SEL_BT0_BIT-SEL_LOW_BIT] =
            src_level[SEL_BT0_BIT-SEL_LOW_BIT] & ~select_next[SEL_BT0_BIT-SEL_LOW_BIT];
        cpu_next[SEL_ADC2_BIT-SEL_LOW_BIT] =
            src_level[SEL_ADC2_BIT-SEL_LOW_BIT] & ~select_next[SEL_ADC2_BIT-SEL_LOW_BIT];
        cpu_next[SEL_ADC1_BIT-SEL_LOW_BIT] =
            src_level[SEL_ADC1_BIT-SEL_LOW_BIT] & ~select_next[SEL_ADC1_BIT-SEL_LOW_BIT];
        // Transfer path takes each source level whose select bit is set, the processor path those with it clear
        dma_next = src_level & select_next;
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cpu_reg <= '0;
            dma_reg <= '0;
            irq_reg <= 1'b0;
        end
        else
        begin
            cpu_reg <= cpu_next;
            dma_reg <= dma_next;
            irq_reg <= irq_next;
        end
    end

    // ========================================
    // Bus response, zero wait states and always OKAY
    logic       ready_next;
    logic       ready_reg;
    logic [1:0] resp_next;
    logic [1:0] resp_reg;

    always_comb
    begin
        // Constant answer kept in a flop so the outputs are registered
        ready_next = 1'b1;
        resp_next  = HRESP_OKAY;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ready_reg <= 1'b1;
            resp_reg  <= HRESP_OKAY;
        end
        else
        begin
            ready_reg <= ready_next;
            resp_reg  <= resp_next;
        end
    end

    // ========================================
    // Outputs
    assign cpu_irq            = cpu_reg;
    assign dma_controller_req = dma_reg;
    assign router_irq         = irq_reg;
    assign hrdata             = hrdata_reg;
    assign hreadyout          = ready_reg;
    assign hresp              = resp_reg;

endmodule
`default_nettype wire

// ---- tb/irq_route_chk.sv ----
// Checker for the routed request outputs
// Assumes sources are low for three cycles before reset ends
`timescale 1ns/100ps
`default_nettype none
module irq_route_chk (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       ser1_rx_irq,
    input wire logic       ser0_tx_irq,
    input wire logic       ser0_rx_irq,
    input wire logic       timer6_irq0,
    input wire logic       timer4_irq0,
    input wire logic       timer2_irq0,
    input wire logic       timer0_irq0,
    input wire logic       adc2_scan_irq,
    input wire logic       adc1_scan_irq,
    input wire logic [8:0] cpu_irq,
    input wire logic [8:0] dma_controller_req
);
    wire logic [8:0] any_req = cpu_irq | dma_controller_req;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ========================================
    // Each source reaches exactly one side
    chk_ser1_rx_path: assert property (any_req[8] == $past(ser1_rx_irq, 3))
        else $error("ser1 rx lost");
    chk_ser0_tx_path: assert property (any_req[7] == $past(ser0_tx_irq, 3))
        else $error("ser0 tx lost");
    chk_ser0_rx_path: assert property (any_req[6] == $past(ser0_rx_irq, 3))
        else $error("ser0 rx lost");
    chk_timer6_path: assert property (any_req[5] == $past(timer6_irq0, 3))
        else $error("timer6 lost");
    chk_timer4_path: assert property (any_req[4] == $past(timer4_irq0, 3))
        else $error("timer4 lost");
    chk_timer2_path: assert property (any_req[3] == $past(timer2_irq0, 3))
        else $error("timer2 lost");
    chk_timer0_path: assert property (any_req[2] == $past(timer0_irq0, 3))
        else $error("timer0 lost");
    chk_adc2_path: assert property (any_req[1] == $past(adc2_scan_irq, 3))
        else $error("adc2 lost");
    chk_adc1_path: assert property (any_req[0] == $past(adc1_scan_irq, 3))
        else $error("adc1 lost");
    chk_one_dest: assert property ((cpu_irq & dma_controller_req) == 9'h000)
        else $error("both sides requested");
endmodule
bind irq_dma_request_router irq_route_chk u_chk (.hclk, .hresetn, .ser1_rx_irq, .ser0_tx_irq,
    .ser0_rx_irq, .timer6_irq0, .timer4_irq0, .timer2_irq0, .timer0_irq0, .adc2_scan_irq,
    .adc1_scan_irq, .cpu_irq, .dma_controller_req);
`default_nettype wire

// ---- tb/irq_dest_model.sv ----
// Processor and transfer-request sinks, capture every request seen
// Assumes level requests on hclk; clr_seen empties the capture
`timescale 1ns/100ps
`default_nettype none
module irq_dest_model (
    input  wire logic       hclk,
    input  wire logic       clr_seen,
    input  wire logic [8:0] cpu_irq,
    input  wire logic [8:0] dma_controller_req,
    output logic      [8:0] cpu_seen_reg,
    output logic      [8:0] dma_seen_reg
);
    always_ff @(posedge hclk)
    begin
        cpu_seen_reg <= clr_seen ? 9'h000 : (cpu_seen_reg | cpu_irq);
        dma_seen_reg <= clr_seen ? 9'h000 : (dma_seen_reg | dma_controller_req);
    end
endmodule
`default_nettype wire

// ---- tb/tb_irq_dma_request_router.sv ----
// Bench for the routing block: bus tasks, routing and interrupt scenarios
// Assumes one slave, hready fed back from hreadyout
`timescale 1ns/100ps
`default_nettype none
module tb_irq_dma_request_router;
    import irq_route_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        clr_seen = 1'b0;
    logic        hreadyout, router_irq;
    logic [1:0]  htrans = 2'h0;
    logic [1:0]  hresp;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd_q, d;
    logic [8:0]  src = 9'h000;
    logic [8:0]  cpu_irq, dma_req, cpu_seen, dma_seen;
    int          n_mismatch = 0;
    int          n_tests = 0;
    always #20 hclk = ~hclk;
    always @(posedge hclk) rd_q <= hrdata;
    irq_dma_request_router dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ser1_rx_irq(src[8]),
        .ser0_tx_irq(src[7]), .ser0_rx_irq(src[6]), .timer6_irq0(src[5]), .timer4_irq0(src[4]),
        .timer2_irq0(src[3]), .timer0_irq0(src[2]), .adc2_scan_irq(src[1]),
        .adc1_scan_irq(src[0]), .cpu_irq, .dma_controller_req(dma_req), .router_irq);
    irq_dest_model sink (.hclk, .clr_seen, .cpu_irq, .dma_controller_req(dma_req),
        .cpu_seen_reg(cpu_seen), .dma_seen_reg(dma_seen));
    // ========================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        #1 d = rd_q;
    endtask
    task automatic drive(input logic [8:0] v, input int n);
        @(posedge hclk);
        src <= v;
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic stop_test;
        $display("mismatches %0d of %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ========================================
    // Scenarios
    initial
    begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, SELECT_OFFSET, 32'h0);
        chk(d, SELECT_RESET);
        bus(1'b0, MASK_OFFSET, 32'h0);
        chk(d, MASK_RESET);
        bus(1'b0, 8'h10, 32'h0);
        chk(d, 32'h0000_0000);
        for (int i = 0; i < NUM_SOURCES; i++)
        begin
            for (int s = 0; s < 2; s++)
            begin
                bus(1'b1, SELECT_OFFSET, (s == 1) ? (32'h1 << (i + SEL_LOW_BIT)) : 32'h0);
                @(posedge hclk);
                clr_seen <= 1'b1;
                @(posedge hclk);
                clr_seen <= 1'b0;
                drive(9'h001 << i, 5);
                drive(9'h000, 5);
                chk({23'h0, cpu_seen}, (s == 0) ? (32'h1 << i) : 32'h0);
                chk({23'h0, dma_seen}, (s == 1) ? (32'h1 << i) : 32'h0);
            end
        end
        chk({31'h0, router_irq}, 32'h0);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk(d, 32'h0000_7FC0);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk(d, 32'h0000_0000);
        bus(1'b1, MASK_OFFSET, 32'h0000_4000);
        drive(9'h1FF, 5);
        chk({31'h0, router_irq}, 32'h1);
        bus(1'b0, LEVEL_OFFSET, 32'h0);
        chk(d, 32'h0000_7FC0);
        chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
        chk({31'h0, hreadyout}, 32'h1);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk(d, 32'h0000_7FC0);
        repeat (3) @(posedge hclk);
        chk({31'h0, router_irq}, 32'h0);
        bus(1'b1, SELECT_OFFSET, 32'hFFFF_FFFF);
        chk({23'h0, dma_req}, 32'h1FF);
        chk({23'h0, cpu_irq}, 32'h0);
        bus(1'b0, SELECT_OFFSET, 32'h0);
        chk(d, 32'h0000_7FC0);
        bus(1'b1, SELECT_OFFSET, 32'h0000_0000);
        chk({23'h0, cpu_irq}, 32'h1FF);
        chk({23'h0, dma_req}, 32'h0);
        bus(1'b1, SELECT_OFFSET, 32'h0000_7FC0);
        @(posedge hclk);
        hresetn <= 1'b0;
        drive(9'h000, 5);
        chk({13'h0, router_irq, dma_req, cpu_irq}, 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, SELECT_OFFSET, 32'h0);
        chk(d, SELECT_RESET);
        bus(1'b0, MASK_OFFSET, 32'h0);
        chk(d, MASK_RESET);
        stop_test();
    end
endmodule
`default_nettype wire
